// >>> hw/fps_cfg.svh
// Constants for the flash protection and command status block
// What this block does
// R1: Polarity 1: each cleared range-disable bit protects its range.
// R2: Polarity 0: both disables set protect all; cleared disable leaves only its range open.
// R3: High size field picks top range from 0xF800, 0xF000, 0xE000 or 0xC000.
// R4: Low size field picks range from 0x4000 ending 0x43FF, 0x47FF, 0x4FFF or 0x5FFF.
// R5: Protection loads from nonvolatile storage after reset; software may still change it.
// R6: A write causing a disallowed scenario transition is dropped whole.
// R7: Allowed transitions: 0->0123, 1->13, 2->23, 3->3, 4->34, 5->2345, 6->1346, 7->any.
// R8: Reading the protection register returns the enforced scenario.
// R9: Normal modes: empty, violation, error writable; complete, blank read-only; rest read 0.
// R10: Special modes: fail becomes writable, inactive becomes readable only.
// R11: Buffer-empty flag bit 7 set when buffers empty; write 1 clears, 0 no effect.
// R12: Writing 0 to buffer-empty mid sequence aborts and sets access error.
// R13: Interrupt when buffer-empty and its enable, or complete and its enable.
// R14: Complete bit 6 clears with buffer-empty; sets only when all commands finish.
// R15: Violation bit 5 sets on protected program/erase; write 1 clears; blocks launch.
// R16: Access error bit 4 sets on sequence error, illegal command, stop while busy.
// R17: Blank bit 2 sets on erased verify; cleared when a valid sequence launches.
// R18: Special modes: fail bit 1 sets on failed verify; write 1 clears; blocks launch.
// R19: Special modes: inactive bit 0 reads 0 while an operation runs.
// R20: Special-mode software must clear fail before starting a new sequence.
// R21: A range size field is writable only while its disable bit is set.
// R22: Polarity and two disables map to scenario 0..7 by fixed encoding.
`ifndef FPS_CFG_SVH
`define FPS_CFG_SVH
`define FPS_ADDR_W        4
`define FPS_OFS_PROT      4'h4
`define FPS_OFS_STAT      4'h5
`define FPS_OFS_CMD       4'h6
`define FPS_OFS_ADDRHI    4'h8
`define FPS_OFS_ADDRLO    4'h9
`define FPS_OFS_DATAHI    4'ha
`define FPS_OFS_DATALO    4'hb
`define FPS_OFS_CNFG      4'h3
`define FPS_BIT_POL       7
`define FPS_BIT_HDIS      5
`define FPS_BIT_LDIS      2
`define FPS_BIT_BUFE      7
`define FPS_BIT_CMPL      6
`define FPS_BIT_VIOL      5
`define FPS_BIT_AERR      4
`define FPS_BIT_BLANK     2
`define FPS_BIT_FAIL      1
`define FPS_BIT_DONE      0
`define FPS_CNFG_BUFEIE   7
`define FPS_CNFG_CMPLIE   6
`define FPS_CMD_VERIFY    7'h05
`define FPS_CMD_PROGRAM   7'h20
`define FPS_CMD_SECTOR    7'h40
`define FPS_CMD_MASS      7'h41
`define FPS_HI_BASE0      16'hf800
`define FPS_HI_BASE1      16'hf000
`define FPS_HI_BASE2      16'he000
`define FPS_HI_BASE3      16'hc000
`define FPS_LO_BASE       16'h4000
`define FPS_LO_END0       16'h43ff
`define FPS_LO_END1       16'h47ff
`define FPS_LO_END2       16'h4fff
`define FPS_LO_END3       16'h5fff
`define FPS_OP_CYCLES     16'd64
`define FPS_TRANS_TABLE   64'hff_5a_3c_18_08_0c_0a_0f
`endif

// >>> hw/fps_pkg.sv
// Types for the flash protection and command status block
package fps_pkg;
  typedef enum logic [1:0] {
    FPS_IDLE  = 2'b00,
    FPS_ADDR  = 2'b01,
    FPS_CMD   = 2'b10
  } fps_seq_t;
  typedef enum logic [1:0] {
    FPS_ENG_IDLE = 2'b00,
    FPS_ENG_RUN  = 2'b01
  } fps_eng_t;
endpackage

// >>> hw/fps_prot_dec.sv
// Protection decoder: scenario index and protected-address check
`timescale 1ns/1ps
`include "fps_cfg.svh"
module fps_prot_dec (
  // Protection setting
  input  wire logic [7:0]  prot,
  // Address under test
  input  wire logic [15:0] addr,
  // Results
  output logic [2:0]       scenario,
  output logic             is_protected
);
  logic [15:0] hi_base;
  logic [15:0] lo_end;
  logic        in_hi;
  logic        in_lo;
  logic        pol;
  logic        hdis;
  logic        ldis;

  // Scenario index is polarity, high disable, low disable read as a number
  assign pol      = prot[`FPS_BIT_POL];
  assign hdis     = prot[`FPS_BIT_HDIS];
  assign ldis     = prot[`FPS_BIT_LDIS];
  assign scenario = {pol, hdis, ldis};  // [R22]

  // Range bounds from the size fields
  assign hi_base = (prot[4:3] == 2'b00) ? `FPS_HI_BASE0 :
                   (prot[4:3] == 2'b01) ? `FPS_HI_BASE1 :
                   (prot[4:3] == 2'b10) ? `FPS_HI_BASE2 : `FPS_HI_BASE3;  // [R3]
  assign lo_end  = (prot[1:0] == 2'b00) ? `FPS_LO_END0 :
                   (prot[1:0] == 2'b01) ? `FPS_LO_END1 :
                   (prot[1:0] == 2'b10) ? `FPS_LO_END2 : `FPS_LO_END3;  // [R4]
  assign in_hi   = (addr >= hi_base);
  assign in_lo   = (addr >= `FPS_LO_BASE) && (addr <= lo_end);

  // Polarity 1 protects enabled ranges, polarity 0 opens them
  assign is_protected = pol ? ((!hdis && in_hi) || (!ldis && in_lo)) :  // [R1]
                        !((!hdis && in_hi) || (!ldis && in_lo));        // [R2]
endmodule

// >>> hw/fps_top.sv
// Flash protection register, command sequencer and status flags on Avalon-MM
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
`include "fps_cfg.svh"
module fps_top (
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      nrst,
  // Avalon-MM slave
  input  wire logic [`FPS_ADDR_W-1:0]    avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  input  wire logic [3:0]                avs_byteenable,
  output logic [31:0]                    avs_readdata,
  output logic                           avs_waitrequest,
  output logic [1:0]                     avs_response,
  // Nonvolatile protection value and its load strobe
  input  wire logic [7:0]                nv_prot,
  input  wire logic                      nv_load,
  // Mode and system inputs
  input  wire logic                      special_mode,
  input  wire logic                      cpu_stop,
  // Array side: write attempts and verify result
  input  wire logic                      array_wr,
  input  wire logic [15:0]               array_addr,
  input  wire logic                      array_erased,
  // Engine outputs
  output logic                           op_launch,
  output logic [6:0]                     op_cmd,
  output logic [15:0]                    op_addr,
  output logic                           flash_irq
);
  import fps_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [7:0]  prot_q, prot_d;
  logic        bufe_q, cmpl_q, viol_q, aerr_q, blank_q, fail_q;
  logic [1:0]  cnfg_q;
  fps_seq_t    seq_q, seq_d;
  fps_eng_t    eng_q;
  logic [15:0] buf_addr_q, run_addr_q;
  logic [6:0]  buf_cmd_q, run_cmd_q;
  logic        pend_q;
  logic [15:0] op_cnt_q;
  logic        ack_q;
  logic [31:0] rdata_q;
  logic [1:0]  resp_q;
  logic        nvl_s1_q, nvl_s2_q, nvl_s3_q;
  logic        stp_s1_q, stp_s2_q;
  logic        awr_s1_q, awr_s2_q;
  logic        spc_s1_q, spc_s2_q;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for pin-level inputs; nv_prot is stable while nv_load is high
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      {nvl_s1_q, nvl_s2_q, nvl_s3_q} <= 3'h0;
      {stp_s1_q, stp_s2_q, awr_s1_q, awr_s2_q, spc_s1_q, spc_s2_q} <= 6'h00;
    end else begin
      nvl_s1_q <= nv_load;
      nvl_s2_q <= nvl_s1_q;
      nvl_s3_q <= nvl_s2_q;
      stp_s1_q <= cpu_stop;
      stp_s2_q <= stp_s1_q;
      awr_s1_q <= array_wr;
      awr_s2_q <= awr_s1_q;
      spc_s1_q <= special_mode;
      spc_s2_q <= spc_s1_q;
    end
  end

  logic nv_load_rise;
  assign nv_load_rise = nvl_s2_q && !nvl_s3_q;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode: one-cycle wait, answer on the second cycle
  logic        req, acc, wr_acc, rd_acc, lane0;
  logic        wr_prot, wr_stat, wr_cmd, wr_cnfg, hit;
  logic [7:0]  wd;
  assign req   = avs_read || avs_write;
  assign acc   = req && ack_q;
  assign wr_acc = acc && avs_write;
  assign rd_acc = req && avs_read && !ack_q;
  assign lane0 = avs_byteenable[0];
  assign wd    = avs_writedata[7:0];
  assign hit   = (avs_address == `FPS_OFS_PROT) || (avs_address == `FPS_OFS_STAT) ||
                 (avs_address == `FPS_OFS_CMD)  || (avs_address == `FPS_OFS_CNFG);
  assign wr_prot = wr_acc && lane0 && (avs_address == `FPS_OFS_PROT);
  assign wr_stat = wr_acc && lane0 && (avs_address == `FPS_OFS_STAT);
  assign wr_cmd  = wr_acc && lane0 && (avs_address == `FPS_OFS_CMD);
  assign wr_cnfg = wr_acc && lane0 && (avs_address == `FPS_OFS_CNFG);
  assign avs_waitrequest = req && !ack_q;
  assign avs_readdata    = rdata_q;
  assign avs_response    = resp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Protection decoder on the live setting and on the array write address
  logic [2:0] cur_scn, new_scn;
  logic       addr_prot;
  logic [7:0] trans_row;
  logic       trans_ok;
  logic [63:0] trans_tab;
  fps_prot_dec u_dec_cur (
    .prot         (prot_q),
    .addr         (buf_addr_q),
    .scenario     (cur_scn),
    .is_protected (addr_prot)
  );

  // Candidate value: size fields only follow the write while disable is set
  always_comb begin
    prot_d = wd;
    if (!prot_q[`FPS_BIT_HDIS]) prot_d[4:3] = prot_q[4:3];  // [R21]
    if (!prot_q[`FPS_BIT_LDIS]) prot_d[1:0] = prot_q[1:0];  // [R21]
    prot_d[6] = prot_q[6];
  end
  assign new_scn   = {prot_d[`FPS_BIT_POL], prot_d[`FPS_BIT_HDIS], prot_d[`FPS_BIT_LDIS]};  // [R22]
  assign trans_tab = `FPS_TRANS_TABLE;
  assign trans_row = trans_tab[cur_scn*8 +: 8];
  assign trans_ok  = trans_row[new_scn];  // [R7]

  // Protection register: nonvolatile load, then add-only software updates
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prot_q <= 8'hff;
    end else if (nv_load_rise) begin
      prot_q <= nv_prot;  // [R5]
    end else if (wr_prot && trans_ok) begin
      prot_q <= prot_d;  // [R5] [R6]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command write sequence: array write, command write, launch by clearing empty
  logic cmd_valid, launch, seq_abort, seq_err, blocked;
  assign cmd_valid = (wd[6:0] == `FPS_CMD_VERIFY) || (wd[6:0] == `FPS_CMD_PROGRAM) ||
                     (wd[6:0] == `FPS_CMD_SECTOR) || (wd[6:0] == `FPS_CMD_MASS);
  // Launch needs error flags clear; a fail left set by software simply blocks
  assign blocked   = viol_q || aerr_q || fail_q;  // [R15] [R16] [R18] [R20]
  assign launch    = wr_stat && wd[`FPS_BIT_BUFE] && (seq_q == FPS_CMD) && !blocked;
  assign seq_abort = wr_stat && !wd[`FPS_BIT_BUFE] && (seq_q != FPS_IDLE);  // [R12]
  assign seq_err   = (wr_cmd && (seq_q != FPS_ADDR)) ||
                     (wr_cmd && (seq_q == FPS_ADDR) && !cmd_valid) ||  // [R16]
                     (awr_s2_q && (seq_q == FPS_CMD)) ||
                     (wr_stat && wd[`FPS_BIT_BUFE] && (seq_q == FPS_ADDR));
  logic stop_err;
  assign stop_err  = stp_s2_q && !cmpl_q;  // [R16]
  logic pv_event;
  assign pv_event  = launch && addr_prot && (buf_cmd_q != `FPS_CMD_VERIFY);  // [R15]

  always_comb begin
    seq_d = seq_q;
    case (seq_q)
      FPS_IDLE: if (awr_s2_q && bufe_q) seq_d = FPS_ADDR;
      FPS_ADDR: if (wr_cmd && cmd_valid) seq_d = FPS_CMD;
      FPS_CMD:  if (launch) seq_d = FPS_IDLE;
      default:  seq_d = FPS_IDLE;
    endcase
    if (seq_abort || seq_err || stop_err || (launch && pv_event)) seq_d = FPS_IDLE;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      seq_q      <= FPS_IDLE;
      buf_addr_q <= 16'h0000;
      buf_cmd_q  <= 7'h00;
    end else begin
      seq_q <= seq_d;
      if (seq_q == FPS_IDLE && awr_s2_q && bufe_q) buf_addr_q <= array_addr;
      if (wr_cmd && seq_q == FPS_ADDR) buf_cmd_q <= wd[6:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage engine: one running command plus one pending in the buffer
  logic good_launch, eng_done, fetch;
  assign good_launch = launch && !pv_event;
  assign eng_done    = (eng_q == FPS_ENG_RUN) && (op_cnt_q == `FPS_OP_CYCLES);
  assign fetch       = pend_q && (eng_q == FPS_ENG_IDLE || eng_done);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      eng_q      <= FPS_ENG_IDLE;
      op_cnt_q   <= 16'h0000;
      pend_q     <= 1'b0;
      run_cmd_q  <= 7'h00;
      run_addr_q <= 16'h0000;
      op_launch  <= 1'b0;
    end else begin
      op_launch <= fetch;
      if (good_launch) pend_q <= 1'b1;
      else if (fetch) pend_q <= 1'b0;
      if (fetch) begin
        eng_q      <= FPS_ENG_RUN;
        op_cnt_q   <= 16'h0000;
        run_cmd_q  <= buf_cmd_q;
        run_addr_q <= buf_addr_q;
      end else if (eng_done) begin
        eng_q <= FPS_ENG_IDLE;
      end else if (eng_q == FPS_ENG_RUN) begin
        op_cnt_q <= op_cnt_q + 16'h0001;
      end
    end
  end
  assign op_cmd  = run_cmd_q;
  assign op_addr = run_addr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Status flags; hardware set wins over a software clear in the same cycle, except complete, where a launch clear wins over the set
  logic verify_end;
  assign verify_end = eng_done && (run_cmd_q == `FPS_CMD_VERIFY);
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bufe_q   <= 1'b1;
      cmpl_q   <= 1'b1;
      viol_q   <= 1'b0;
      aerr_q   <= 1'b0;
      blank_q  <= 1'b0;
      fail_q   <= 1'b0;
      cnfg_q   <= 2'b00;
    end else begin
      // Empty drops on launch and returns once the buffer is fetched
      if (fetch || (seq_abort && !good_launch)) bufe_q <= 1'b1;  // [R11]
      else if (good_launch) bufe_q <= 1'b0;  // [R11]
      // Complete clears with empty, sets only when nothing runs or waits
      if (good_launch) cmpl_q <= 1'b0;  // [R14]
      else if (eng_done && !pend_q) cmpl_q <= 1'b1;  // [R14]
      if (pv_event) viol_q <= 1'b1;  // [R15]
      else if (wr_stat && wd[`FPS_BIT_VIOL]) viol_q <= 1'b0;  // [R15]
      if (seq_abort || seq_err || stop_err) aerr_q <= 1'b1;  // [R12] [R16]
      else if (wr_stat && wd[`FPS_BIT_AERR]) aerr_q <= 1'b0;  // [R16]
      if (verify_end && array_erased) blank_q <= 1'b1;  // [R17]
      else if (good_launch) blank_q <= 1'b0;  // [R17]
      if (verify_end && !array_erased && spc_s2_q) fail_q <= 1'b1;  // [R18]
      else if (wr_stat && spc_s2_q && wd[`FPS_BIT_FAIL]) fail_q <= 1'b0;  // [R10] [R18]
      if (wr_cnfg) cnfg_q <= wd[7:6];
    end
  end

  // Interrupt from either enabled source
  assign flash_irq = (bufe_q && cnfg_q[1]) || (cmpl_q && cnfg_q[0]);  // [R13]

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; special-mode bits read 0 in normal modes
  logic [7:0] stat_rd, rd_byte;
  assign stat_rd = {bufe_q, cmpl_q, viol_q, aerr_q, 1'b0, blank_q,  // [R9]
                    spc_s2_q & fail_q,  // [R10]
                    spc_s2_q & (eng_q == FPS_ENG_IDLE)};  // [R10] [R19]
  assign rd_byte = (avs_address == `FPS_OFS_PROT) ? prot_q :  // [R8]
                   (avs_address == `FPS_OFS_STAT) ? stat_rd :
                   (avs_address == `FPS_OFS_CNFG) ? {cnfg_q, 6'h00} : 8'h00;

  // Ack register gives a fixed one-cycle wait; unmapped addresses answer with an error
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
      resp_q  <= 2'b00;
    end else begin
      ack_q <= req && !ack_q;
      if (rd_acc) rdata_q <= {24'h00_0000, rd_byte};
      if (req && !ack_q) resp_q <= hit ? 2'b00 : 2'b11;
    end
  end
endmodule

// >>> verif/fps_top_properties.sv
// Port-level properties of the flash protection and status block
`timescale 1ns/1ps
`include "fps_cfg.svh"
module fps_top_properties (
  // Clock and reset
  input wire logic                   core_clk,
  input wire logic                   nrst,
  // Register bus
  input wire logic [`FPS_ADDR_W-1:0] avs_address,
  input wire logic                   avs_read,
  input wire logic                   avs_write,
  input wire logic [31:0]            avs_readdata,
  input wire logic                   avs_waitrequest,
  input wire logic [1:0]             avs_response,
  // Mode and engine
  input wire logic                   special_mode,
  input wire logic                   op_launch,
  input wire logic [6:0]             op_cmd
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  //////////////////////////////////////////////
  // A status read answered in this cycle
  sequence rd_stat;
    avs_read && !avs_waitrequest && avs_address == `FPS_OFS_STAT;
  endsequence
  // Status read soon after a launch, long before a 64-cycle run can end
  sequence busy_rd;
    op_launch ##[2:20] rd_stat;
  endsequence
  //////////////////////////////////////////////
  first_stall_a: assert property ((avs_read || avs_write) && !$past(avs_read || avs_write) |-> avs_waitrequest)
    else $error("first request cycle not stalled");
  one_wait_a: assert property (avs_waitrequest && (avs_read || avs_write) |=> !avs_waitrequest)
    else $error("request stalled longer than one cycle");
  launch_pulse_a: assert property (op_launch |=> !op_launch)
    else $error("launch pulse wider than one cycle");
  unmapped_read_a: assert property (avs_read && !avs_waitrequest && avs_address inside {4'h7, 4'hc, 4'hf}
    |-> avs_response == 2'b11 && avs_readdata == 32'h0)
    else $error("unmapped read not refused");
  zero_bits_a: assert property ((!special_mode) [*4] ##0 rd_stat |-> {avs_readdata[3], avs_readdata[1:0]} == 3'h0)
    else $error("normal mode status low bits not zero");
  launch_blocked_a: assert property ((rd_stat and (avs_readdata[5:4] != 2'b00)) |=> !op_launch [*2])
    else $error("launch while error flag set");
  legal_cmd_a: assert property (op_launch |-> op_cmd inside {7'h05, 7'h20, 7'h40, 7'h41})
    else $error("illegal command launched");
  busy_flags_a: assert property (busy_rd |-> !avs_readdata[6] && !avs_readdata[0])
    else $error("complete or inactive set while running");
  empty_complete_a: assert property ((rd_stat and !avs_readdata[7]) |-> !avs_readdata[6])
    else $error("complete set while buffer full");
endmodule
bind fps_top fps_top_properties u_props (.core_clk(core_clk), .nrst(nrst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .avs_response(avs_response), .special_mode(special_mode), .op_launch(op_launch), .op_cmd(op_cmd));

// >>> verif/fps_top_test.sv
// Self-checking bench for the flash protection and status block
`timescale 1ns/1ps
`include "fps_cfg.svh"
module fps_top_test;
  import fps_pkg::*;
  // Clock, reset and bus
  logic                   core_clk = 1'b0;
  logic                   nrst = 1'b0;
  logic [`FPS_ADDR_W-1:0] avs_address = 4'h0;
  logic                   avs_read = 1'b0;
  logic                   avs_write = 1'b0;
  logic [31:0]            avs_writedata = 32'h0;
  logic [31:0]            avs_readdata;
  logic                   avs_waitrequest;
  logic [1:0]             avs_response;
  // Pins and engine
  logic [7:0]             nv_prot = 8'hff;
  logic                   nv_load = 1'b0;
  logic                   special_mode = 1'b0;
  logic                   cpu_stop = 1'b0;
  logic                   array_wr = 1'b0;
  logic [15:0]            array_addr = 16'h0;
  logic                   array_erased = 1'b0;
  logic                   op_launch;
  logic [6:0]             op_cmd;
  logic [15:0]            op_addr;
  logic                   flash_irq;
  // Bench state
  logic [7:0]             pv;
  logic                   pe;
  logic [7:0]             q;
  logic [1:0]             rsp;
  int                     failures = 0;
  int                     comparisons = 0;
  int                     launches = 0;
  int                     n;
  logic [7:0]             allow_tbl [8] = '{8'h0f, 8'h0a, 8'h0c, 8'h08, 8'h18, 8'h3c, 8'h5a, 8'hff};
  logic [6:0]             cmds [4] = '{7'h05, 7'h20, 7'h40, 7'h41};
  logic [15:0]            pts [19] = '{16'h3fff, 16'h4000, 16'h43ff, 16'h4400, 16'h47ff, 16'h4800, 16'h4fff,
    16'h5000, 16'h5fff, 16'h6000, 16'hbfff, 16'hc000, 16'hdfff, 16'he000, 16'hefff, 16'hf000, 16'hf7ff,
    16'hf800, 16'hffff};
  //////////////////////////////////////////////
  fps_top DUT (.core_clk(core_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .nv_prot(nv_prot), .nv_load(nv_load),
    .special_mode(special_mode), .cpu_stop(cpu_stop), .array_wr(array_wr), .array_addr(array_addr),
    .array_erased(array_erased), .op_launch(op_launch), .op_cmd(op_cmd), .op_addr(op_addr),
    .flash_irq(flash_irq));
  // Clock and launch counter
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (op_launch === 1'b1) launches <= launches + 1;
  //////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One bus access; request held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= {24'h0, d};
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    rsp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e, input string nm);
    acc(1'b0, a, 8'h00);
    chk(nm, {24'h0, q & m}, {24'h0, e});
  endtask
  task automatic irqc(input logic e);
    #1;
    chk("irq", {31'h0, flash_irq}, {31'h0, e});
  endtask
  // Array write, command write, then status write
  task automatic cmd_seq(input logic [15:0] ad, input logic [6:0] c, input logic [7:0] s);
    @(posedge core_clk);
    array_addr <= ad;
    array_wr <= 1'b1;
    repeat (4) @(posedge core_clk);
    array_wr <= 1'b0;
    acc(1'b1, `FPS_OFS_CMD, {1'b0, c});
    acc(1'b1, `FPS_OFS_STAT, s);
  endtask
  task automatic nvl(input logic [7:0] v);
    @(posedge core_clk);
    nv_prot <= v;
    nv_load <= 1'b1;
    repeat (4) @(posedge core_clk);
    nv_load <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  function automatic logic prot_exp(input logic [7:0] p, input logic [15:0] a);
    logic hi;
    logic lo;
    hi = a >= (16'hffff << (5'h0b + p[4:3]));
    lo = a >= 16'h4000 && a < 16'h4000 + (16'h0400 << p[1:0]);
    if (p[7]) return (!p[5] && hi) || (!p[2] && lo);
    return (p[5] && p[2]) || !((!p[5] && hi) || (!p[2] && lo));
  endfunction
  function automatic logic [7:0] sv(input logic [2:0] s);
    return {s[2], 1'b1, s[1], 2'b00, s[0], 2'b00};
  endfunction
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////
  // Watchdog, well beyond the expected run of some 170 us
  initial begin
    #400000;
    failures++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    rc(`FPS_OFS_STAT, 8'hff, 8'hc0, "stat");
    chk("resp", {30'h0, rsp}, 32'h0);
    rc(`FPS_OFS_PROT, 8'hff, 8'hff, "prot");
    acc(1'b1, 4'h7, 8'hff);
    rc(4'h7, 8'hff, 8'h00, "rsvd");
    chk("resp", {30'h0, rsp}, 32'h3);
    $display("test reset done");
    // Every scenario and size, probed by program attempts; a free address runs the full operation
    for (int p = 0; p < 32; p++) begin
      nvl(8'hff);
      pv = sv(p[4:2]) | {3'h0, p[1:0], 1'b0, p[1:0]};
      acc(1'b1, `FPS_OFS_PROT, pv);
      rc(`FPS_OFS_PROT, 8'hff, pv, "scen");
      for (int i = 0; i < 19; i++) begin
        pe = prot_exp(pv, pts[i]);
        cmd_seq(pts[i], `FPS_CMD_PROGRAM, 8'h80);
        repeat (pe ? 2 : 70) @(posedge core_clk);
        rc(`FPS_OFS_STAT, 8'h20, {2'b00, pe, 5'h00}, "dec");
        acc(1'b1, `FPS_OFS_STAT, 8'h20);
      end
    end
    $display("test decoder done");
    for (int f = 0; f < 8; f++) begin
      for (int t = 0; t < 8; t++) begin
        nvl(sv(f[2:0]));
        acc(1'b1, `FPS_OFS_PROT, sv(t[2:0]));
        rc(`FPS_OFS_PROT, 8'hff, allow_tbl[f][t] ? sv(t[2:0]) : sv(f[2:0]), "trans");
      end
    end
    $display("test transitions done");
    nvl(8'hff);
    acc(1'b1, `FPS_OFS_PROT, 8'hed);
    rc(`FPS_OFS_PROT, 8'hff, 8'hed, "size");
    acc(1'b1, `FPS_OFS_PROT, 8'he0);
    acc(1'b1, `FPS_OFS_PROT, 8'he3);
    rc(`FPS_OFS_PROT, 8'hff, 8'he0, "size");
    nvl(8'he0);
    rc(`FPS_OFS_PROT, 8'hff, 8'he0, "load");
    n = launches;
    cmd_seq(16'h4010, `FPS_CMD_PROGRAM, 8'h80);
    rc(`FPS_OFS_STAT, 8'h20, 8'h20, "viol");
    cmd_seq(16'h4400, `FPS_CMD_PROGRAM, 8'h80);
    chk("launch", launches, n);
    acc(1'b1, `FPS_OFS_STAT, 8'h20);
    rc(`FPS_OFS_STAT, 8'h30, 8'h10, "viol");
    acc(1'b1, `FPS_OFS_STAT, 8'h10);
    $display("test protection done");
    acc(1'b1, `FPS_OFS_CNFG, 8'h40);
    irqc(1'b1);
    cmd_seq(16'h4400, `FPS_CMD_PROGRAM, 8'h80);
    cmd_seq(16'h4402, `FPS_CMD_PROGRAM, 8'h80);
    #1;
    chk("launch", launches, n + 1);
    chk("op", {9'h0, op_cmd, op_addr}, {9'h0, `FPS_CMD_PROGRAM, 16'h4400});
    irqc(1'b0);
    repeat (70) @(posedge core_clk);
    rc(`FPS_OFS_STAT, 8'h40, 8'h00, "pend");
    repeat (70) @(posedge core_clk);
    rc(`FPS_OFS_STAT, 8'hff, 8'hc0, "done");
    chk("launch", launches, n + 2);
    acc(1'b1, `FPS_OFS_CNFG, 8'h80);
    irqc(1'b1);
    acc(1'b1, `FPS_OFS_CNFG, 8'h00);
    irqc(1'b0);
    $display("test commands done");
    cmd_seq(16'h4400, `FPS_CMD_PROGRAM, 8'h00);
    rc(`FPS_OFS_STAT, 8'h10, 8'h10, "abort");
    acc(1'b1, `FPS_OFS_STAT, 8'h10);
    acc(1'b1, `FPS_OFS_STAT, 8'h00);
    rc(`FPS_OFS_STAT, 8'h10, 8'h00, "err");
    cmd_seq(16'h4400, 7'h7f, 8'h80);
    rc(`FPS_OFS_STAT, 8'h10, 8'h10, "illegal");
    acc(1'b1, `FPS_OFS_STAT, 8'h10);
    nvl(8'hff);
    for (int i = 0; i < 4; i++) begin
      cmd_seq(16'h8000, cmds[i], 8'h80);
      repeat (80) @(posedge core_clk);
      chk("cmd", {25'h0, op_cmd}, {25'h0, cmds[i]});
    end
    rc(`FPS_OFS_STAT, 8'hff, 8'hc0, "stat");
    $display("test errors done");
    special_mode <= 1'b1;
    repeat (4) @(posedge core_clk);
    rc(`FPS_OFS_STAT, 8'hff, 8'hc1, "spec");
    cmd_seq(16'h8000, `FPS_CMD_VERIFY, 8'h80);
    rc(`FPS_OFS_STAT, 8'h01, 8'h00, "active");
    repeat (80) @(posedge core_clk);
    rc(`FPS_OFS_STAT, 8'hff, 8'hc3, "fail");
    acc(1'b1, `FPS_OFS_STAT, 8'h02);
    rc(`FPS_OFS_STAT, 8'hff, 8'hc1, "fail");
    array_erased <= 1'b1;
    cmd_seq(16'h8000, `FPS_CMD_VERIFY, 8'h80);
    repeat (80) @(posedge core_clk);
    rc(`FPS_OFS_STAT, 8'hff, 8'hc5, "blank");
    cmd_seq(16'h8000, `FPS_CMD_PROGRAM, 8'h80);
    rc(`FPS_OFS_STAT, 8'h04, 8'h00, "blank");
    cpu_stop <= 1'b1;
    repeat (4) @(posedge core_clk);
    cpu_stop <= 1'b0;
    rc(`FPS_OFS_STAT, 8'h10, 8'h10, "stop");
    $display("test special done");
    tally_and_finish();
  end
endmodule
